//--- design/sbr_cfg.svh
// Constants of the SPI register map: offsets, fields and frame figures
`ifndef SBR_CFG_SVH
`define SBR_CFG_SVH

`define SBR_FRAME_BITS 5'h10
`define SBR_NUM_REGS 21
`define SBR_LAST_ADDR 5'h14

`define SBR_OP_HI 15
`define SBR_OP_LO 14
`define SBR_ADDR_HI 13
`define SBR_ADDR_LO 9
`define SBR_PN_BIT 8
`define SBR_PARITY_EN_BIT 6

`define SBR_ADDR_ANALOG_SELECT_CTRL 5'h00
`define SBR_ADDR_SCRATCH_BYTE_A 5'h01
`define SBR_ADDR_SCRATCH_BYTE_B 5'h02
`define SBR_ADDR_SCRATCH_BYTE_C 5'h03
`define SBR_ADDR_SCRATCH_BYTE_D 5'h04
`define SBR_ADDR_INIT_REGULATORS 5'h05
`define SBR_ADDR_INIT_WATCHDOG 5'h06
`define SBR_ADDR_INIT_SERIAL_AND_IO 5'h07
`define SBR_ADDR_INIT_MISCELLANEOUS 5'h08
`define SBR_ADDR_PROTECTED_MODE_SELECT 5'h09
`define SBR_ADDR_TIMER_WATCHDOG_LPCONS 5'h0a
`define SBR_ADDR_TIMER_CYCLIC_SENSE_INT 5'h0b
`define SBR_ADDR_TIMER_LP_WD_FORCED_WAKE 5'h0c
`define SBR_ADDR_WATCHDOG_REFRESH 5'h0d
`define SBR_ADDR_OPERATING_MODE 5'h0e
`define SBR_ADDR_REGULATOR_CONTROL 5'h0f
`define SBR_ADDR_CAN_PORT_CONTROL 5'h10
`define SBR_ADDR_IO_PIN_CONTROL 5'h11
`define SBR_ADDR_INTERRUPT_CONTROL 5'h12
`define SBR_ADDR_LIN_PORT1_CONTROL 5'h13
`define SBR_ADDR_LIN_PORT2_CONTROL 5'h14

`define SBR_REG_RESET 8'h00
`define SBR_FLAG_BASE 15

`endif

//--- design/sbr_pkg.sv
// Types shared by the SPI register map modules
`default_nettype none
package sbr_pkg;
	typedef logic [7:0] sbr_byte_t;
	typedef logic [4:0] sbr_addr_t;
	typedef enum logic [1:0] {
		SBR_OP_READBACK = 2'h0,
		SBR_OP_WRITE = 2'h1,
		SBR_OP_RESERVED = 2'h2,
		SBR_OP_FLAGS = 2'h3
	} sbr_op_t;
endpackage
`default_nettype wire

//--- design/sbr_link_if.sv
// Carrier between the SPI link logic and the register core
`include "sbr_cfg.svh"
`default_nettype none
interface sbr_link_if;
	import sbr_pkg::*;
	logic [15:0] word;
	logic [4:0] len;
	sbr_byte_t status;
	sbr_byte_t ext_status;
	sbr_byte_t rd_bank [`SBR_NUM_REGS];
	sbr_byte_t flag_bank [`SBR_NUM_REGS];
	modport link (output word, output len, input status, input ext_status, input rd_bank, input flag_bank);
	modport core (input word, input len, output status, output ext_status, output rd_bank, output flag_bank);
endinterface
`default_nettype wire

//--- design/sbr_spi_link.sv
// SPI shift logic on the serial clock: command capture and answer shifting
`include "sbr_cfg.svh"
`default_nettype none
module sbr_spi_link
	import sbr_pkg::*;
(
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso_o,
	output logic spi_miso_oe,
	sbr_link_if.link lk
);
	logic first_q;
	logic [4:0] len_q;
	logic [15:0] shift_q;
	logic [3:0] rcnt_q;
	sbr_byte_t head_q;
	sbr_op_t head_op;
	sbr_addr_t head_addr;
	sbr_byte_t lo_byte;

	// Marks the first falling edge of a frame
	always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	// Samples MOSI, counts bits, saturating
	always_ff @(negedge spi_sclk) begin
		shift_q <= {shift_q[14:0], spi_mosi};
		if (first_q) begin
			len_q <= 5'h01;
		end else if (len_q != 5'h1f) begin
			len_q <= len_q + 5'h01;
		end
	end

	// Holds the command head from its eighth bit to the end of the frame
	always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			head_q <= 8'h00;
		end else if (!first_q && (len_q == 5'h07)) begin
			head_q <= {shift_q[6:0], spi_mosi};
		end
	end

	assign lk.word = shift_q;
	assign lk.len = len_q;

	// Head stays fixed while the low byte is shifted out
	assign head_op = sbr_op_t'(head_q[7:6]);
	assign head_addr = head_q[5:1];

	always_comb begin
		lo_byte = 8'h00;
		unique case (head_op)
			SBR_OP_WRITE: lo_byte = lk.ext_status;
			SBR_OP_READBACK: begin
				if (head_addr <= `SBR_LAST_ADDR) begin
					lo_byte = lk.rd_bank[head_addr];
				end
			end
			SBR_OP_FLAGS: begin
				if (head_addr <= `SBR_LAST_ADDR) begin
					lo_byte = lk.flag_bank[head_addr];
				end
			end
			SBR_OP_RESERVED: lo_byte = 8'h00;
		endcase
	end

	// Drives one answer bit per rising edge: status byte, then low byte
	always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			rcnt_q <= 4'h0;
			spi_miso_o <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			rcnt_q <= rcnt_q + 4'h1;
			spi_miso_oe <= 1'b1;
			if (!rcnt_q[3]) begin
				spi_miso_o <= lk.status[3'h7 - rcnt_q[2:0]];
			end else begin
				spi_miso_o <= lo_byte[3'h7 - rcnt_q[2:0]];
			end
		end
	end
endmodule
`default_nettype wire

//--- design/sbr_reg_map.sv
// Register address decoder and map behind the 16-bit SPI slave
`include "sbr_cfg.svh"
`default_nettype none
module sbr_reg_map
	import sbr_pkg::*;
#(
	parameter int NUM_REGS = `SBR_NUM_REGS
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso_o,
	output logic spi_miso_oe,
	input wire logic [7:0] dev_status,
	input wire logic [7:0] dev_ext_status,
	input wire logic [47:0] dev_flags,
	input wire logic [7:0] current_mode,
	input wire logic [7:0] random_code,
	output logic [NUM_REGS*8-1:0] reg_bank,
	output logic wd_refresh,
	output logic spec_mode_req,
	output logic mode_write,
	output logic debug_exit,
	output logic flag_read,
	output logic [4:0] flag_read_addr,
	output logic parity_err
);
	sbr_link_if lk ();

	logic cs_s1_q;
	logic cs_s2_q;
	logic cs_s3_q;
	logic frame_end;
	logic idle;
	logic cmd_vld_q;
	logic [15:0] cmd_q;
	sbr_op_t cmd_op;
	sbr_addr_t cmd_addr;
	sbr_byte_t cmd_data;
	logic addr_ok;
	logic parity_ok;
	logic wr_ok;
	sbr_byte_t bank_q [NUM_REGS];
	sbr_byte_t status_q;
	sbr_byte_t ext_q;
	sbr_byte_t mode_img_q;
	sbr_byte_t rnd_img_q;
	sbr_byte_t flag_img_q [6];

	sbr_spi_link u_link (
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.spi_miso_o(spi_miso_o),
		.spi_miso_oe(spi_miso_oe),
		.lk(lk.link)
	);

	// Chip select into the reference domain
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
		end else begin
			cs_s1_q <= spi_cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
		end
	end

	assign frame_end = cs_s2_q && !cs_s3_q;
	assign idle = cs_s2_q && cs_s3_q;

	// Captures the finished word; link data is static once select is high
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmd_vld_q <= 1'b0;
			cmd_q <= 16'h0000;
		end else begin
			cmd_vld_q <= frame_end && (lk.len == `SBR_FRAME_BITS);
			if (frame_end) begin
				cmd_q <= lk.word;
			end
		end
	end

	assign cmd_op = sbr_op_t'(cmd_q[`SBR_OP_HI:`SBR_OP_LO]);
	assign cmd_addr = cmd_q[`SBR_ADDR_HI:`SBR_ADDR_LO];
	assign cmd_data = cmd_q[7:0];
	assign addr_ok = cmd_addr <= `SBR_LAST_ADDR;
	// Odd count of ones over all 16 bits when parity is in use
	assign parity_ok = !bank_q[`SBR_ADDR_INIT_MISCELLANEOUS][`SBR_PARITY_EN_BIT] || (^cmd_q);
	assign wr_ok = cmd_vld_q && (cmd_op == SBR_OP_WRITE) && addr_ok && parity_ok;

	// Device inputs are frozen while a frame runs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status_q <= 8'h00;
			ext_q <= 8'h00;
			mode_img_q <= 8'h00;
			rnd_img_q <= 8'h00;
		end else if (idle) begin
			status_q <= dev_status;
			ext_q <= dev_ext_status;
			mode_img_q <= current_mode;
			rnd_img_q <= random_code;
		end
	end

	assign lk.status = status_q;
	assign lk.ext_status = ext_q;

	// Storage and read-back per address
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_bank
		localparam sbr_addr_t ADDR = sbr_addr_t'(i);
		logic hit;
		assign hit = wr_ok && (cmd_addr == ADDR);

		always_ff @(posedge ref_clk) begin
			if (rst) begin
				bank_q[i] <= `SBR_REG_RESET;
			end else if (hit) begin
				if (ADDR == `SBR_ADDR_PROTECTED_MODE_SELECT) begin
					if (cmd_data == ~rnd_img_q) begin
						bank_q[i] <= cmd_data;
					end
				end else if (ADDR != `SBR_ADDR_WATCHDOG_REFRESH) begin
					bank_q[i] <= cmd_data;
				end
			end
		end

		always_comb begin
			if (ADDR == `SBR_ADDR_PROTECTED_MODE_SELECT) begin
				lk.rd_bank[i] = rnd_img_q;
			end else if (ADDR == `SBR_ADDR_WATCHDOG_REFRESH) begin
				lk.rd_bank[i] = 8'h00;
			end else if (ADDR == `SBR_ADDR_OPERATING_MODE) begin
				lk.rd_bank[i] = mode_img_q;
			end else begin
				lk.rd_bank[i] = bank_q[i];
			end
		end

		if (i >= `SBR_FLAG_BASE) begin : g_flag
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					flag_img_q[i - `SBR_FLAG_BASE] <= 8'h00;
				end else if (idle) begin
					flag_img_q[i - `SBR_FLAG_BASE] <= dev_flags[(i - `SBR_FLAG_BASE) * 8 +: 8];
				end
			end
			assign lk.flag_bank[i] = flag_img_q[i - `SBR_FLAG_BASE];
		end else begin : g_noflag
			assign lk.flag_bank[i] = 8'h00;
		end

		assign reg_bank[i * 8 +: 8] = bank_q[i];
	end

	// Watchdog refresh on any valid command to its address except the reserved op; writes need good parity
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wd_refresh <= 1'b0;
		end else begin
			wd_refresh <= cmd_vld_q && (cmd_op != SBR_OP_RESERVED) && (cmd_addr == `SBR_ADDR_WATCHDOG_REFRESH)
				&& ((cmd_op != SBR_OP_WRITE) || parity_ok);
		end
	end

	// Protected mode request only with the inverted code
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			spec_mode_req <= 1'b0;
		end else begin
			spec_mode_req <= wr_ok && (cmd_addr == `SBR_ADDR_PROTECTED_MODE_SELECT) && (cmd_data == ~rnd_img_q);
		end
	end

	// Mode selection write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_write <= 1'b0;
		end else begin
			mode_write <= wr_ok && (cmd_addr == `SBR_ADDR_OPERATING_MODE);
		end
	end

	// Reading the mode register ends debug mode
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			debug_exit <= 1'b0;
		end else begin
			debug_exit <= cmd_vld_q && (cmd_op == SBR_OP_READBACK) && (cmd_addr == `SBR_ADDR_OPERATING_MODE);
		end
	end

	// Flag read notice with its address
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flag_read <= 1'b0;
			flag_read_addr <= 5'h00;
		end else begin
			flag_read <= cmd_vld_q && (cmd_op == SBR_OP_FLAGS) && addr_ok
				&& (cmd_addr >= `SBR_ADDR_REGULATOR_CONTROL);
			if (cmd_vld_q && (cmd_op == SBR_OP_FLAGS)) begin
				flag_read_addr <= cmd_addr;
			end
		end
	end

	// Rejected write on bad parity
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			parity_err <= 1'b0;
		end else begin
			parity_err <= cmd_vld_q && (cmd_op == SBR_OP_WRITE) && !parity_ok;
		end
	end
endmodule
`default_nettype wire

//--- sim/sbr_reg_map_properties.sv
// Checker of the SPI register map top-level ports
`default_nettype none
module sbr_reg_map_properties
	import sbr_pkg::*;
#(
	parameter int NUM_REGS = 21
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic spi_miso_o,
	input wire logic spi_miso_oe,
	input wire logic [7:0] dev_status,
	input wire logic [7:0] dev_ext_status,
	input wire logic [47:0] dev_flags,
	input wire logic [7:0] current_mode,
	input wire logic [7:0] random_code,
	input wire logic [NUM_REGS*8-1:0] reg_bank,
	input wire logic wd_refresh,
	input wire logic spec_mode_req,
	input wire logic mode_write,
	input wire logic debug_exit,
	input wire logic flag_read,
	input wire logic [4:0] flag_read_addr,
	input wire logic parity_err
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	chk_miso_idle: assert property ($past(spi_cs_n) && spi_cs_n |-> !spi_miso_oe && !spi_miso_o)
		else $error("miso driven while idle");
	chk_pulse_width: assert property (wd_refresh || debug_exit |=> !wd_refresh && !debug_exit)
		else $error("pulse longer than one cycle");
	chk_after_frame: assert property (wd_refresh || spec_mode_req || mode_write || debug_exit || flag_read
		|-> spi_cs_n && $past(spi_cs_n, 3))
		else $error("command acted on inside frame");
	chk_one_command: assert property ($onehot0({wd_refresh, spec_mode_req, mode_write, debug_exit, flag_read}))
		else $error("several command pulses");
	chk_refresh_empty: assert property (reg_bank[111:104] == 8'h00)
		else $error("refresh address stores data");
	chk_bank_frame: assert property (!spi_cs_n && !$past(spi_cs_n) |-> $stable(reg_bank))
		else $error("register changed inside frame");
	chk_flag_addr: assert property (flag_read |-> ##[0:1] flag_read_addr >= 5'h0f && flag_read_addr <= 5'h14)
		else $error("flag read of non flag address");
	chk_spec_code: assert property (spec_mode_req |-> ##[0:1] reg_bank[79:72] == ~random_code)
		else $error("protected write without inverted code");
endmodule
bind sbr_reg_map sbr_reg_map_properties #(.NUM_REGS(NUM_REGS)) u_sbr_reg_map_properties (.ref_clk(ref_clk),
	.rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
	.spi_miso_oe(spi_miso_oe), .dev_status(dev_status), .dev_ext_status(dev_ext_status), .dev_flags(dev_flags),
	.current_mode(current_mode), .random_code(random_code), .reg_bank(reg_bank), .wd_refresh(wd_refresh),
	.spec_mode_req(spec_mode_req), .mode_write(mode_write), .debug_exit(debug_exit), .flag_read(flag_read),
	.flag_read_addr(flag_read_addr), .parity_err(parity_err));
`default_nettype wire

//--- sim/sbr_spi_master.sv
// Model of the MCU as SPI master, 12 ns serial clock
`default_nettype none
module sbr_spi_master
	import sbr_pkg::*;
(
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// One 16-bit frame, MSB first, shift on rise, sample on fall
	task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
		cs_n = 1'b0;
		#20;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b1;
			mosi = cmd[i];
			#6;
			sclk = 1'b0;
			rsp[i] = miso;
			#6;
		end
		#10;
		cs_n = 1'b1;
		mosi = ~mosi;
		#60;
	endtask
endmodule
`default_nettype wire

//--- sim/sbr_reg_map_test.sv
// Self-checking bench of the SPI register map
`default_nettype none
module sbr_reg_map_test
	import sbr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk, rst, sclk, cs_n, mosi, miso, miso_oe, wd, spec, mw, dbg, fr, perr;
	logic [7:0] st, ext, mode, rcode;
	logic [47:0] flags;
	logic [167:0] bank;
	logic [4:0] fr_addr;
	logic [15:0] rsp;
	sbr_byte_t d;
	sbr_byte_t exp_q [21];
	int n_fail = 0, samples_checked = 0, seed = 32'h1dfb, cyc = 0;
	int n_wd = 0, n_spec = 0, n_mw = 0, n_dbg = 0, n_fr = 0, n_perr = 0;
	int e_wd = 0, e_spec = 0, e_mw = 0, e_dbg = 0, e_fr = 0, e_perr = 0;
	logic par_en = 1'b0;
	logic p_bad = 1'b0;
	sbr_reg_map u_sbr_reg_map (.ref_clk(ref_clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
		.spi_miso_o(miso), .spi_miso_oe(miso_oe), .dev_status(st), .dev_ext_status(ext), .dev_flags(flags),
		.current_mode(mode), .random_code(rcode), .reg_bank(bank), .wd_refresh(wd), .spec_mode_req(spec),
		.mode_write(mw), .debug_exit(dbg), .flag_read(fr), .flag_read_addr(fr_addr), .parity_err(perr));
	sbr_spi_master u_sbr_spi_master (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		n_wd <= n_wd + (wd === 1'b1);
		n_spec <= n_spec + (spec === 1'b1);
		n_mw <= n_mw + (mw === 1'b1);
		n_dbg <= n_dbg + (dbg === 1'b1);
		n_fr <= n_fr + (fr === 1'b1);
		n_perr <= n_perr + (perr === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			n_fail = n_fail + 1;
			stop_test();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic new_inputs();
		st = 8'($random(seed));
		ext = 8'($random(seed));
		flags = {16'($random(seed)), 32'($random(seed))};
		mode = 8'($random(seed));
	endtask
	function automatic sbr_byte_t rd_exp(input logic [1:0] op, input logic [4:0] a);
		if (op == 2'b11) return (a >= 5'h0f && a <= 5'h14) ? flags[(a - 5'h0f) * 8 +: 8] : 8'h00;
		if (op != 2'b00 || a > 5'h14 || a == 5'h0d) return 8'h00;
		if (a == 5'h09) return rcode;
		if (a == 5'h0e) return mode;
		return exp_q[a];
	endfunction
	task automatic acc(input logic [1:0] op, input logic [4:0] a, input sbr_byte_t dv);
		sbr_byte_t lo;
		logic [11:0] seen_p, exp_p;
		logic [15:0] cmd;
		logic p_ok;
		@(negedge ref_clk);
		new_inputs();
		lo = (op == 2'b01) ? ext : rd_exp(op, a);
		cmd = {op, a, op != 2'b01, dv};
		if (op == 2'b01 && par_en) cmd[8] = (~^{cmd[15:9], cmd[7:0]}) ^ p_bad;
		p_ok = (op != 2'b01) || !par_en || (^cmd);
		u_sbr_spi_master.xfer(cmd, rsp);
		if (p_ok && op == 2'b01 && a <= 5'h14 && a != 5'h0d && (a != 5'h09 || dv === ~rcode)) exp_q[a] = dv;
		if (p_ok && op == 2'b01 && a == 5'h08) par_en = dv[6];
		e_wd += (a == 5'h0d && op != 2'b10 && p_ok);
		e_spec += (p_ok && op == 2'b01 && a == 5'h09 && dv === ~rcode);
		e_mw += (p_ok && op == 2'b01 && a == 5'h0e);
		e_perr += !p_ok;
		e_dbg += (op == 2'b00 && a == 5'h0e);
		e_fr += (op == 2'b11 && a >= 5'h0f && a <= 5'h14);
		seen_p = {n_wd[1:0], n_spec[1:0], n_mw[1:0], n_dbg[1:0], n_fr[1:0], n_perr[1:0]};
		exp_p = {e_wd[1:0], e_spec[1:0], e_mw[1:0], e_dbg[1:0], e_fr[1:0], e_perr[1:0]};
		check(rsp, {st, lo}, "miso word");
		check(16'(seen_p), 16'(exp_p), "pulse counts");
		if (op == 2'b11 && a >= 5'h0f && a <= 5'h14) check(16'(fr_addr), 16'(a), "flag address");
		for (int i = 0; i < 21; i++) check(16'(bank[i*8 +: 8]), 16'(exp_q[i]), "bank byte");
	endtask
	initial begin
		rst = 1'b1;
		rcode = 8'h00;
		new_inputs();
		foreach (exp_q[i]) exp_q[i] = 8'h00;
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		rcode = 8'($random(seed));
		repeat (3) @(negedge ref_clk);
		for (int a = 0; a < 32; a++) begin
			d = 8'($random(seed));
			if (a == 8) d[6] = 1'b0;
			acc(2'b01, 5'(a), d);
		end
		for (int a = 0; a < 32; a++) acc(2'b00, 5'(a), 8'h00);
		$display("write and read-back test done");
		for (int a = 0; a < 32; a++) acc(2'b10, 5'(a), 8'($random(seed)));
		for (int a = 0; a < 21; a++) if (a != 13 && a != 14) acc(2'b11, 5'(a), 8'h00);
		$display("flag and reserved test done");
		acc(2'b01, 5'h09, ~rcode ^ 8'h01);
		acc(2'b01, 5'h09, ~rcode);
		acc(2'b00, 5'h09, 8'h00);
		$display("protected mode test done");
		acc(2'b01, 5'h08, 8'h40);
		p_bad = 1'b1;
		acc(2'b01, 5'h01, 8'($random(seed)));
		acc(2'b01, 5'h0d, 8'h00);
		p_bad = 1'b0;
		acc(2'b01, 5'h01, 8'($random(seed)));
		acc(2'b01, 5'h08, 8'h00);
		$display("parity test done");
		@(negedge ref_clk);
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		foreach (exp_q[i]) exp_q[i] = 8'h00;
		par_en = 1'b0;
		repeat (3) @(negedge ref_clk);
		acc(2'b00, 5'h01, 8'h00);
		acc(2'b00, 5'h08, 8'h00);
		$display("mid-run reset test done");
		stop_test();
	end
endmodule
`default_nettype wire
